/* File: logic/encoder_counter_channel.sv */
// One 32-bit encoder counter channel with preload, capture and ref logic
// Functional notes
// - Mode 00: A direction, B clock, C trigger
// - Modes 01/10/11: quadrature 1x, 2x, 4x
// - Direction bit reverses counting
// - Invert bit flips A,B and ref quadrant
// - Preload command copies preload value to counter
// - Zero command clears the counter
// - Selector 0 off, 1/2 clear on ref, 3 timer
// - Selector 4/5 load on next/every ref
// - Selector 6 clear on ref, reload at underflow
// - Selector 7 loads on aux input 1/3/5
// - Software capture into capture register 0 or 1
// - Sync pulse to all channels, optional cascade
// - Capture trigger 0 off, 1 sync, 2 timer, 3 sync input
// - Capture trigger 4 uses aux input 2/4/6
// - Capture trigger 5/6/7: first, second, every ref
// - Inhibit bit makes aux 1/3/5 block ref marks
// - Two-bit status: first and second ref passed
// - Ref clear restarts mark recognition
// - Report live A, B, C levels
// - Report live encoder fault level
// - Timer zero crossing is a trigger event
`timescale 1ns/100ps
`default_nettype none

module encoder_counter_channel
  import enc_pkg::*;
#(
  parameter int CHAN_IDX = 0
) (
  input  wire logic             mclk_in,
  input  wire logic             sys_rst_in,
  input  wire logic             track_a_in,
  input  wire logic             track_b_in,
  input  wire logic             track_c_in,
  input  wire logic             encoder_fault_in,
  input  wire logic [AUX_N-1:0] aux_in,
  input  wire logic             sync_input_in,
  input  wire logic             timer_zero_in,
  input  wire logic [3:0]       evaluation_mode_select_in,
  input  wire logic [2:0]       hw_load_clear_select_in,
  input  wire logic [2:0]       capture0_trigger_select_in,
  input  wire logic [2:0]       capture1_trigger_select_in,
  input  wire logic [2:0]       ref_inhibit_config_in,
  input  wire logic             preload_value_write_in,
  input  wire logic [CNT_W-1:0] preload_value_in,
  input  wire logic             software_preload_in,
  input  wire logic             software_zero_in,
  input  wire logic             software_capture_in,
  input  wire logic             capture_select_in,
  input  wire logic             sync_capture_pulse_in,
  input  wire logic             cascade_enable_in,
  input  wire logic             ref_status_clear_in,
  output logic      [CNT_W-1:0] count_out,
  output logic      [CNT_W-1:0] capture0_value_out,
  output logic      [CNT_W-1:0] capture1_value_out,
  output logic      [1:0]       ref_traversed_status_out,
  output logic      [2:0]       track_level_status_out,
  output logic                  encoder_fault_status_out,
  output logic                  cascade_output_out
);

  // Aux inputs wired to this channel (load/inhibit, capture)
  localparam int AUX_LD  = 2 * CHAN_IDX;
  localparam int AUX_CAP = 2 * CHAN_IDX + 1;

  // ------------------------------------------------------------------
  // Capture trigger decode, shared by both capture registers
  // ------------------------------------------------------------------
  function automatic logic cap_hit(input logic [2:0] sel,
                                   input logic sync_p, input logic tmr,
                                   input logic sync_r, input logic aux_r,
                                   input logic first, input logic second,
                                   input logic any_ref);
    case (sel)
      CAP_OFF:        cap_hit = 1'b0;
      CAP_SYNC_PULSE: cap_hit = sync_p;
      CAP_TIMER:      cap_hit = tmr;
      CAP_SYNC_IN:    cap_hit = sync_r;
      CAP_AUX:        cap_hit = aux_r;
      CAP_REF_FIRST:  cap_hit = first;
      CAP_REF_SECOND: cap_hit = second;
      CAP_REF_ALL:    cap_hit = any_ref;
      default:        cap_hit = 1'b0;
    endcase
  endfunction : cap_hit

  logic [2:0]       trk_lvl;
  logic [2:0]       trk_prev;
  logic [7:0]       io_lvl;
  logic [7:0]       io_rise;
  logic             a_eff;
  logic             b_eff;
  logic             ap_eff;
  logic             bp_eff;
  logic             step;
  logic             up;
  logic             ref_now;
  logic             ref_was;
  logic             inhibit;
  logic             ref_evt;
  logic [1:0]       ref_base;
  logic             first_mark;
  logic             second_mark;
  logic             hw_clr;
  logic             hw_ld;
  logic             neg_cross;
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic [CNT_W-1:0] preload_q;
  logic [CNT_W-1:0] preload_d;
  logic [CNT_W-1:0] cap0_q;
  logic [CNT_W-1:0] cap0_d;
  logic [CNT_W-1:0] cap1_q;
  logic [CNT_W-1:0] cap1_d;
  logic [1:0]       ref_q;
  logic [1:0]       ref_d;
  logic [2:0]       trk_q;
  logic             fault_q;
  logic             casc_q;
  logic             casc_d;

  // ------------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------------
  sync_edge #(.WIDTH(3)) u_trk_sync (
    .mclk_in    (mclk_in),
    .sys_rst_in (sys_rst_in),
    .async_in   ({track_c_in, track_b_in, track_a_in}),
    .level_out  (trk_lvl),
    .prev_out   (trk_prev),
    .rise_out   ()
  );

  // Aux, sync input and fault share one synchroniser
  sync_edge #(.WIDTH(8)) u_io_sync (
    .mclk_in    (mclk_in),
    .sys_rst_in (sys_rst_in),
    .async_in   ({encoder_fault_in, sync_input_in, aux_in}),
    .level_out  (io_lvl),
    .prev_out   (),
    .rise_out   (io_rise)
  );

  // ------------------------------------------------------------------
  // Track conditioning and quadrant evaluation
  // ------------------------------------------------------------------
  always_comb begin
    a_eff  = trk_lvl[TRK_A_BIT]  ^ evaluation_mode_select_in[MODE_INV_BIT];
    b_eff  = trk_lvl[TRK_B_BIT]  ^ evaluation_mode_select_in[MODE_INV_BIT];
    ap_eff = trk_prev[TRK_A_BIT] ^ evaluation_mode_select_in[MODE_INV_BIT];
    bp_eff = trk_prev[TRK_B_BIT] ^ evaluation_mode_select_in[MODE_INV_BIT];
  end

  quad_eval u_quad (
    .a_in       (a_eff),
    .b_in       (b_eff),
    .a_prev_in  (ap_eff),
    .b_prev_in  (bp_eff),
    .eval_in    (evaluation_mode_select_in[MODE_EVAL_HI:MODE_EVAL_LO]),
    .dir_inv_in (evaluation_mode_select_in[MODE_DIR_BIT]),
    .step_out   (step),
    .up_out     (up)
  );

  // ------------------------------------------------------------------
  // Reference mark detection and status
  // ------------------------------------------------------------------
  always_comb begin
    // Plain counting uses C alone; encoders qualify it by quadrant
    if (evaluation_mode_select_in[MODE_EVAL_HI:MODE_EVAL_LO] == EVAL_PLAIN)
    begin
      ref_now = trk_lvl[TRK_C_BIT];
      ref_was = trk_prev[TRK_C_BIT];
    end else begin
      ref_now = a_eff & b_eff & trk_lvl[TRK_C_BIT];
      ref_was = ap_eff & bp_eff & trk_prev[TRK_C_BIT];
    end
    inhibit = ref_inhibit_config_in[CHAN_IDX] & io_lvl[AUX_LD];
    ref_evt = ref_now & ~ref_was & ~inhibit;
    // A clear in the same cycle as a mark makes it the first mark
    ref_base    = ref_status_clear_in ? REF_RST : ref_q;
    first_mark  = ref_evt & ~ref_base[REF_FIRST_BIT];
    second_mark = ref_evt & ref_base[REF_FIRST_BIT]
                  & ~ref_base[REF_SECOND_BIT];
    ref_d = ref_base;
    if (first_mark) begin
      ref_d[REF_FIRST_BIT] = 1'b1;
    end
    if (second_mark) begin
      ref_d[REF_SECOND_BIT] = 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Hardware load/clear selection
  // ------------------------------------------------------------------
  always_comb begin
    hw_clr = 1'b0;
    hw_ld  = 1'b0;
    case (hw_load_clear_select_in)
      LDCLR_OFF:        hw_clr = 1'b0;
      LDCLR_CLR_NEXT:   hw_clr = first_mark;
      LDCLR_CLR_ALL:    hw_clr = ref_evt;
      LDCLR_CLR_TIMER:  hw_clr = timer_zero_in;
      LDCLR_LD_NEXT:    hw_ld  = first_mark;
      LDCLR_LD_ALL:     hw_ld  = ref_evt;
      LDCLR_CLR_NEG_LD: hw_clr = ref_evt;
      LDCLR_LD_AUX:     hw_ld  = io_rise[AUX_LD];
      default:          hw_clr = 1'b0;
    endcase
    neg_cross = step & ~up & (count_q == COUNT_RST);
  end

  // ------------------------------------------------------------------
  // Counter and preload next values
  // ------------------------------------------------------------------
  always_comb begin
    preload_d = preload_value_write_in ? preload_value_in : preload_q;
    // Software commands outrank hardware triggers, which outrank steps
    if (software_zero_in) begin
      count_d = COUNT_RST;
    end else if (software_preload_in) begin
      count_d = preload_q;
    end else if (hw_clr) begin
      count_d = COUNT_RST;
    end else if (hw_ld) begin
      count_d = preload_q;
    end else if (step) begin
      if (neg_cross && hw_load_clear_select_in == LDCLR_CLR_NEG_LD) begin
        count_d = preload_q;
      end else if (up) begin
        count_d = count_q + 32'h0000_0001;
      end else begin
        count_d = count_q - 32'h0000_0001;
      end
    end else begin
      count_d = count_q;
    end
  end

  // ------------------------------------------------------------------
  // Capture registers and cascade pulse
  // ------------------------------------------------------------------
  always_comb begin
    cap0_d = cap0_q;
    cap1_d = cap1_q;
    if ((software_capture_in && !capture_select_in) ||
        cap_hit(capture0_trigger_select_in, sync_capture_pulse_in,
                timer_zero_in, io_rise[AUX_N], io_rise[AUX_CAP],
                first_mark, second_mark, ref_evt)) begin
      cap0_d = count_q;
    end
    if ((software_capture_in && capture_select_in) ||
        cap_hit(capture1_trigger_select_in, sync_capture_pulse_in,
                timer_zero_in, io_rise[AUX_N], io_rise[AUX_CAP],
                first_mark, second_mark, ref_evt)) begin
      cap1_d = count_q;
    end
    casc_d = sync_capture_pulse_in & cascade_enable_in;
  end

  // ------------------------------------------------------------------
  // State registers
  // ------------------------------------------------------------------
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      count_q   <= COUNT_RST;
      preload_q <= PRELOAD_RST;
      cap0_q    <= CAPTURE_RST;
      cap1_q    <= CAPTURE_RST;
      ref_q     <= REF_RST;
      trk_q     <= 3'h0;
      fault_q   <= 1'b0;
      casc_q    <= 1'b0;
    end else begin
      count_q   <= count_d;
      preload_q <= preload_d;
      cap0_q    <= cap0_d;
      cap1_q    <= cap1_d;
      ref_q     <= ref_d;
      trk_q     <= trk_lvl;
      fault_q   <= io_lvl[AUX_N+1];
      casc_q    <= casc_d;
    end
  end

  // Outputs straight from flops
  assign count_out                = count_q;
  assign capture0_value_out       = cap0_q;
  assign capture1_value_out       = cap1_q;
  assign ref_traversed_status_out = ref_q;
  assign track_level_status_out   = trk_q;
  assign encoder_fault_status_out = fault_q;
  assign cascade_output_out       = casc_q;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);

  sequence casc_req_s;
    sync_capture_pulse_in && cascade_enable_in;
  endsequence
  sequence casc_pulse_s;
    cascade_output_out;
  endsequence

  zero_cmd_a:
    assert property (software_zero_in |=> count_q == COUNT_RST)
      else $error("software zero did not clear counter");
  preload_cmd_a:
    assert property (software_preload_in && !software_zero_in
                     |=> count_q == $past(preload_q))
      else $error("software preload did not load counter");
  timer_clear_a:
    assert property (!software_zero_in && !software_preload_in &&
                     hw_load_clear_select_in == LDCLR_CLR_TIMER &&
                     timer_zero_in |=> count_q == COUNT_RST)
      else $error("timer zero crossing did not clear counter");
  neg_reload_a:
    assert property (!software_zero_in && !software_preload_in &&
                     !hw_clr && neg_cross &&
                     hw_load_clear_select_in == LDCLR_CLR_NEG_LD
                     |=> count_q == $past(preload_q))
      else $error("underflow reload missing");
  count_wrap_a:
    assert property (!software_zero_in && !software_preload_in &&
                     !hw_clr && !hw_ld && step && up &&
                     count_q == 32'hffff_ffff |=> count_q == COUNT_RST)
      else $error("counter did not wrap to zero");
  sw_capture_a:
    assert property (software_capture_in && !capture_select_in
                     |=> cap0_q == $past(count_q))
      else $error("software capture 0 missed count");
  cascade_out_a:
    assert property (casc_req_s |=> casc_pulse_s)
      else $error("sync pulse not sent to cascade output");
  cascade_idle_a:
    assert property (!cascade_enable_in |=> !cascade_output_out)
      else $error("cascade output pulsed while disabled");
  ref_first_a:
    assert property (first_mark |=> ref_q[REF_FIRST_BIT])
      else $error("first reference mark not recorded");
  ref_clear_a:
    assert property (ref_status_clear_in && !ref_evt |=> ref_q == REF_RST)
      else $error("reference status not cleared");
  ref_inhibit_a:
    assert property (inhibit && !ref_status_clear_in
                     |=> ref_q == $past(ref_q))
      else $error("inhibited reference mark changed status");
  track_level_a:
    assert property (##3 1'b1 |-> track_level_status_out ==
                     {$past(track_c_in, 3), $past(track_b_in, 3),
                      $past(track_a_in, 3)})
      else $error("track level status does not follow inputs");

endmodule : encoder_counter_channel

`default_nettype wire

/* File: logic/enc_pkg.sv */
// Shared constants for the encoder counter channel
package enc_pkg;

  // ------------------------------------------------------------------
  // Widths and reset values
  // ------------------------------------------------------------------
  localparam int          CNT_W        = 32;
  localparam int          AUX_N        = 6;
  localparam logic [31:0] COUNT_RST    = 32'h0000_0000;
  localparam logic [31:0] PRELOAD_RST  = 32'h0000_0000;
  localparam logic [31:0] CAPTURE_RST  = 32'h0000_0000;
  localparam logic [1:0]  REF_RST      = 2'h0;

  // ------------------------------------------------------------------
  // Evaluation mode field positions and values
  // ------------------------------------------------------------------
  localparam int         MODE_EVAL_LO = 0;
  localparam int         MODE_EVAL_HI = 1;
  localparam int         MODE_DIR_BIT = 2;
  localparam int         MODE_INV_BIT = 3;
  localparam logic [1:0] EVAL_PLAIN   = 2'h0;
  localparam logic [1:0] EVAL_X1      = 2'h1;
  localparam logic [1:0] EVAL_X2      = 2'h2;
  localparam logic [1:0] EVAL_X4      = 2'h3;

  // ------------------------------------------------------------------
  // Hardware load/clear selector values
  // ------------------------------------------------------------------
  localparam logic [2:0] LDCLR_OFF        = 3'h0;
  localparam logic [2:0] LDCLR_CLR_NEXT   = 3'h1;
  localparam logic [2:0] LDCLR_CLR_ALL    = 3'h2;
  localparam logic [2:0] LDCLR_CLR_TIMER  = 3'h3;
  localparam logic [2:0] LDCLR_LD_NEXT    = 3'h4;
  localparam logic [2:0] LDCLR_LD_ALL     = 3'h5;
  localparam logic [2:0] LDCLR_CLR_NEG_LD = 3'h6;
  localparam logic [2:0] LDCLR_LD_AUX     = 3'h7;

  // ------------------------------------------------------------------
  // Capture trigger selector values
  // ------------------------------------------------------------------
  localparam logic [2:0] CAP_OFF        = 3'h0;
  localparam logic [2:0] CAP_SYNC_PULSE = 3'h1;
  localparam logic [2:0] CAP_TIMER      = 3'h2;
  localparam logic [2:0] CAP_SYNC_IN    = 3'h3;
  localparam logic [2:0] CAP_AUX        = 3'h4;
  localparam logic [2:0] CAP_REF_FIRST  = 3'h5;
  localparam logic [2:0] CAP_REF_SECOND = 3'h6;
  localparam logic [2:0] CAP_REF_ALL    = 3'h7;

  // ------------------------------------------------------------------
  // Status bit positions
  // ------------------------------------------------------------------
  localparam int REF_FIRST_BIT  = 0;
  localparam int REF_SECOND_BIT = 1;
  localparam int TRK_A_BIT      = 0;
  localparam int TRK_B_BIT      = 1;
  localparam int TRK_C_BIT      = 2;

endpackage : enc_pkg

/* File: logic/sync_edge.sv */
// Two-stage input synchroniser with edge detection
`timescale 1ns/100ps
`default_nettype none

module sync_edge #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk_in,
  input  wire logic             sys_rst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] level_out,
  output logic      [WIDTH-1:0] prev_out,
  output logic      [WIDTH-1:0] rise_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] prev_q;

  // ------------------------------------------------------------------
  // Stages; meta_q feeds sync_q only, never the edge logic
  // ------------------------------------------------------------------
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Edge detect on the settled stages
  assign level_out = sync_q;
  assign prev_out  = prev_q;
  assign rise_out  = sync_q & ~prev_q;

endmodule : sync_edge

`default_nettype wire

/* File: logic/quad_eval.sv */
// Quadrant evaluator: turns track transitions into count steps
`timescale 1ns/100ps
`default_nettype none

module quad_eval
  import enc_pkg::*;
(
  input  wire logic       a_in,
  input  wire logic       b_in,
  input  wire logic       a_prev_in,
  input  wire logic       b_prev_in,
  input  wire logic [1:0] eval_in,
  input  wire logic       dir_inv_in,
  output logic            step_out,
  output logic            up_out
);

  logic a_chg;
  logic b_chg;
  logic dir;

  // ------------------------------------------------------------------
  // Step and direction decode
  // ------------------------------------------------------------------
  always_comb begin
    a_chg = a_in ^ a_prev_in;
    b_chg = b_in ^ b_prev_in;
    // A leading B counts up; both tracks moving at once is dropped
    dir   = a_in ^ b_prev_in;
    case (eval_in)
      EVAL_PLAIN: begin
        step_out = b_in & ~b_prev_in;
        dir      = a_in;
      end
      EVAL_X1:    step_out = a_chg & ~b_in & ~b_chg;
      EVAL_X2:    step_out = a_chg & ~b_chg;
      EVAL_X4:    step_out = a_chg ^ b_chg;
      default:    step_out = 1'b0;
    endcase
    up_out = dir ^ dir_inv_in;
  end

endmodule : quad_eval

`default_nettype wire

/* File: tb/enc_model.sv */
// Encoder model: quadrature tracks, reference track and fault line
`timescale 1ns/100ps
`default_nettype none

module enc_model (
  input  wire logic clk_in,
  output logic      a_out,
  output logic      b_out,
  output logic      c_out,
  output logic      fault_out
);
  // Lines start low like an encoder at rest in quadrant zero
  initial begin
    {fault_out, c_out, b_out, a_out} = 4'h0;
  end

  // Drive {fault,C,B,A}; held 4 edges so sync and edge stages see it
  task automatic put(input logic [3:0] v);
    @(posedge clk_in) {fault_out, c_out, b_out, a_out} <= v;
    repeat (4) @(posedge clk_in);
    #1;
  endtask : put

  // One track per step only, so a real Gray sequence; A leads going up
  task automatic walk(input int n, input logic up);
    for (int i = 0; i < n; i++) begin
      if (up)
        put({fault_out, c_out, a_out, ~b_out});
      else
        put({fault_out, c_out, ~a_out, b_out});
    end
  endtask : walk
endmodule : enc_model
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for one encoder counter channel
`timescale 1ns/100ps
`default_nettype none

module testbench
  import enc_pkg::*;
;
  localparam logic [31:0] PV = 32'h89ab_cdef; // Preload value
  logic             mclk_in = 1'b0;
  logic             sys_rst_in = 1'b1;
  logic [6:0]       cmd = 7'h00;
  logic [AUX_N-1:0] aux_in = '0;
  logic [3:0]       evaluation_mode_select_in = 4'h0;
  logic [2:0]       hw_load_clear_select_in = 3'h0;
  logic [2:0]       capture0_trigger_select_in = 3'h0;
  logic [2:0]       capture1_trigger_select_in = 3'h0;
  logic [2:0]       ref_inhibit_config_in = 3'h0;
  logic [CNT_W-1:0] preload_value_in = PV;
  logic             sync_input_in = 1'b0;
  logic             capture_select_in = 1'b0;
  logic             cascade_enable_in = 1'b0;
  logic             track_a_in, track_b_in, track_c_in, encoder_fault_in;
  logic [CNT_W-1:0] count_out, capture0_value_out, capture1_value_out;
  logic [1:0]       ref_traversed_status_out;
  logic [2:0]       track_level_status_out;
  logic             encoder_fault_status_out, cascade_output_out;
  int               num_errors = 0;
  int               n_checks = 0;

  // Channel 2 so the third inhibit bit and aux bits 4/5 are used
  encoder_counter_channel #(.CHAN_IDX(2)) dut (
    .mclk_in, .sys_rst_in, .track_a_in, .track_b_in, .track_c_in,
    .encoder_fault_in, .aux_in, .sync_input_in, .timer_zero_in(cmd[5]),
    .evaluation_mode_select_in, .hw_load_clear_select_in,
    .capture0_trigger_select_in, .capture1_trigger_select_in,
    .ref_inhibit_config_in, .preload_value_write_in(cmd[6]),
    .preload_value_in, .software_preload_in(cmd[1]),
    .software_zero_in(cmd[0]), .software_capture_in(cmd[2]),
    .capture_select_in, .sync_capture_pulse_in(cmd[4]),
    .cascade_enable_in, .ref_status_clear_in(cmd[3]), .count_out,
    .capture0_value_out, .capture1_value_out,
    .ref_traversed_status_out, .track_level_status_out,
    .encoder_fault_status_out, .cascade_output_out);
  enc_model enc (.clk_in(mclk_in), .a_out(track_a_in), .b_out(track_b_in),
                 .c_out(track_c_in), .fault_out(encoder_fault_in));

  initial begin
    forever #5 mclk_in = ~mclk_in;
  end

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic tk(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask : tk

  // One-cycle strobe; results are read 1 ns after the taking edge
  task automatic pulse(input int k);
    @(posedge mclk_in) cmd <= 7'h01 << k;
    @(posedge mclk_in) cmd <= 7'h00;
    #1;
  endtask : pulse

  task automatic cfg(input logic [3:0] m, input logic [2:0] l, c0, c1);
    @(posedge mclk_in) evaluation_mode_select_in <= m;
    hw_load_clear_select_in <= l;
    capture0_trigger_select_in <= c0;
    capture1_trigger_select_in <= c1;
    #1;
  endtask : cfg

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_modes;
    for (int m = 1; m < 4; m++) begin
      cfg(4'(m), LDCLR_OFF, CAP_OFF, CAP_OFF);
      pulse(0);
      enc.walk(4, 1'b1);
      chk("count", count_out, 32'h1 << (m - 1));
    end
    cfg(4'h7, LDCLR_OFF, CAP_OFF, CAP_OFF);
    pulse(0);
    enc.walk(4, 1'b1);
    chk("count", count_out, 32'hffff_fffc);
    enc.walk(4, 1'b0);
    chk("count", count_out, 32'h0);
    $display("modes done");
  endtask : t_modes

  task automatic t_load;
    pulse(6);
    pulse(1);
    chk("count", count_out, PV);
    @(posedge mclk_in) cmd <= 7'h03; // Zero must beat preload
    @(posedge mclk_in) cmd <= 7'h00;
    #1;
    chk("count", count_out, 32'h0);
    $display("load done");
  endtask : t_load

  task automatic t_ref;
    cfg(4'h0, LDCLR_LD_NEXT, CAP_REF_FIRST, CAP_REF_SECOND);
    pulse(3);
    enc.put(4'h1);
    enc.put(4'h3);
    chk("count", count_out, 32'h1);
    enc.put(4'h7);
    enc.put(4'h3);
    chk("count", count_out, PV);
    chk("cap0", capture0_value_out, 32'h1);
    chk("refst", 32'(ref_traversed_status_out), 32'h1);
    enc.put(4'h1);
    enc.put(4'h3);
    enc.put(4'h7);
    enc.put(4'h3);
    chk("count", count_out, PV + 32'h1);
    chk("cap1", capture1_value_out, PV + 32'h1);
    chk("refst", 32'(ref_traversed_status_out), 32'h3);
    cfg(4'h0, LDCLR_CLR_ALL, CAP_REF_FIRST, CAP_REF_SECOND);
    enc.put(4'h7);
    enc.put(4'h3);
    chk("count", count_out, 32'h0);
    chk("cap0", capture0_value_out, 32'h1);
    pulse(3);
    chk("refst", 32'(ref_traversed_status_out), 32'h0);
    enc.put(4'h2);
    enc.put(4'h0);
    enc.put(4'h2);
    chk("count", count_out, 32'hffff_ffff);
    cfg(4'h0, LDCLR_CLR_NEG_LD, CAP_OFF, CAP_OFF);
    enc.put(4'h6);
    enc.put(4'h2);
    chk("count", count_out, 32'h0);
    enc.put(4'h0);
    enc.put(4'h2);
    chk("count", count_out, PV);
    enc.put(4'h0);
    cfg(4'h0, LDCLR_CLR_NEXT, CAP_OFF, CAP_OFF);
    enc.put(4'h4);
    chk("count", count_out, PV);
    enc.put(4'h0);
    pulse(3);
    enc.put(4'h4);
    chk("count", count_out, 32'h0);
    cfg(4'h0, LDCLR_LD_ALL, CAP_REF_ALL, CAP_OFF);
    enc.put(4'h2);
    enc.put(4'h6);
    chk("count", count_out, PV);
    chk("cap0", capture0_value_out, 32'hffff_ffff);
    enc.put(4'h0);
    $display("ref done");
  endtask : t_ref

  task automatic t_quad;
    cfg(4'h3, LDCLR_OFF, CAP_OFF, CAP_OFF);
    pulse(3);
    enc.put(4'h4);
    enc.put(4'h0);
    chk("refst", 32'(ref_traversed_status_out), 32'h0);
    cfg(4'hb, LDCLR_OFF, CAP_OFF, CAP_OFF);
    enc.put(4'h4);
    enc.put(4'h0);
    chk("refst", 32'(ref_traversed_status_out), 32'h1);
    $display("quadrant done");
  endtask : t_quad

  task automatic t_caps;
    cfg(4'h0, LDCLR_OFF, CAP_SYNC_PULSE, CAP_TIMER);
    pulse(1);
    @(posedge mclk_in) capture_select_in <= 1'b1;
    pulse(2);
    chk("cap1", capture1_value_out, PV);
    pulse(0);
    @(posedge mclk_in) capture_select_in <= 1'b0;
    pulse(2);
    chk("cap0", capture0_value_out, 32'h0);
    pulse(1);
    @(posedge mclk_in) cascade_enable_in <= 1'b1;
    pulse(4);
    chk("cascade", 32'(cascade_output_out), 32'h1);
    chk("cap0", capture0_value_out, PV);
    @(posedge mclk_in) cascade_enable_in <= 1'b0;
    #1;
    chk("cascade", 32'(cascade_output_out), 32'h0);
    pulse(0);
    pulse(5);
    chk("cap1", capture1_value_out, 32'h0);
    chk("cap0", capture0_value_out, PV);
    pulse(4);
    chk("cascade", 32'(cascade_output_out), 32'h0);
    chk("cap0", capture0_value_out, 32'h0);
    cfg(4'h0, LDCLR_OFF, CAP_SYNC_IN, CAP_AUX);
    pulse(1);
    @(posedge mclk_in) sync_input_in <= 1'b1;
    aux_in <= 6'h20;
    tk(4);
    chk("cap0", capture0_value_out, PV);
    chk("cap1", capture1_value_out, PV);
    $display("capture done");
  endtask : t_caps

  task automatic t_aux;
    cfg(4'h0, LDCLR_LD_AUX, CAP_OFF, CAP_OFF);
    pulse(0);
    @(posedge mclk_in) aux_in <= 6'h10;
    sync_input_in <= 1'b0;
    tk(4);
    chk("count", count_out, PV);
    cfg(4'h0, LDCLR_CLR_TIMER, CAP_OFF, CAP_OFF);
    pulse(5);
    chk("count", count_out, 32'h0);
    @(posedge mclk_in) ref_inhibit_config_in <= 3'h4;
    pulse(3);
    enc.put(4'h4);
    enc.put(4'h0);
    chk("refst", 32'(ref_traversed_status_out), 32'h0);
    @(posedge mclk_in) ref_inhibit_config_in <= 3'h3;
    enc.put(4'h4);
    enc.put(4'h0);
    chk("refst", 32'(ref_traversed_status_out), 32'h1);
    $display("inhibit done");
  endtask : t_aux

  task automatic t_live;
    enc.put(4'hd);
    chk("levels", 32'(track_level_status_out), 32'h5);
    chk("fault", 32'(encoder_fault_status_out), 32'h1);
    enc.put(4'h0);
    chk("levels", 32'(track_level_status_out), 32'h0);
    chk("fault", 32'(encoder_fault_status_out), 32'h0);
    $display("levels done");
  endtask : t_live

  // Watchdog: a hang counts as a mismatch and ends the run
  initial begin
    repeat (20000) @(posedge mclk_in);
    num_errors++;
    stop_test();
  end

  initial begin
    repeat (2) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    t_modes();
    t_load();
    t_ref();
    t_quad();
    t_caps();
    t_aux();
    t_live();
    stop_test();
  end
endmodule : testbench
`default_nettype wire
